// >>> dv/bffs_asserts.sv
// checker for the buck fault status flags: read timing, parity, fields, buck gating
// assumes it is bound to bffs_top and sees only its ports
`timescale 1ns/100ps
module bffs_asserts
    import bffs_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clk_en,
    // watched inputs
    input wire logic limp_home_mode,
    input wire logic ch1_tw2_hot,
    input wire logic ch2_tw1_hot,
    input wire logic ch2_cycle_end,
    input wire logic ch2_at_max_on,
    input wire logic rd_strobe,
    input wire logic rd_clear,
    input wire logic [3:0] rd_addr,
    // watched outputs
    input wire logic [23:0] rd_data,
    input wire logic rd_valid,
    input wire logic ch1_buck_en,
    input wire logic ch2_buck_en
);
    // ****************************************
    // properties
    // ****************************************
    default clocking dclk @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic take;
    assign take = rd_strobe && clk_en;
    AST_ANSWER_NEXT: assert property (take |=> rd_valid)
        else $error("read answer missing");
    // a frozen clock enable holds the last answer, so only a live cycle must drop it
    AST_NO_SPURIOUS: assert property (clk_en && !rd_strobe |=> !rd_valid)
        else $error("answer without read");
    AST_ODD_PARITY: assert property (rd_valid |-> ^rd_data)
        else $error("status word parity even");
    AST_UNMAPPED: assert property (take && rd_addr != BFFS_ADDR_STATUS1
        && rd_addr != BFFS_ADDR_STATUS2 |=> rd_data == 24'h00_0001)
        else $error("unmapped read not empty");
    AST_RESERVED: assert property (take && rd_addr == BFFS_ADDR_STATUS2
        |=> rd_data[18:1] == 18'h0_0000) else $error("unused field set");
    AST_WARN2_LIVE: assert property ((ch1_tw2_hot && clk_en)[*6] ##0
        (take && rd_addr == BFFS_ADDR_STATUS1) |=> rd_data[S1_CH1_WARN2])
        else $error("level two warning not shown");
    AST_WARN1_LIVE: assert property ((ch2_tw1_hot && clk_en)[*6] ##0
        (take && rd_addr == BFFS_ADDR_STATUS2) |=> rd_data[S2_CH2_WARN1])
        else $error("level one warning not shown");
    AST_SHORT_GATES: assert property (rd_valid && rd_data[S1_CH1_SHORT] && clk_en
        && !limp_home_mode && !$past(rd_clear) |=> !ch1_buck_en)
        else $error("buck one runs with short flag");
    AST_CH2_OVERTEMP_FLAG_GATES: assert property (rd_valid && rd_data[S2_CH2_OVT] && clk_en
        && !$past(rd_clear) |=> !ch2_buck_en) else $error("buck two runs when hot");
    // second of two back-to-back cycle ends at maximum on-time; a hit re-arms the pair
    logic max_prev_reg;
    logic long_hit;
    assign long_hit = clk_en && ch2_cycle_end && ch2_at_max_on && max_prev_reg;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            max_prev_reg <= 1'b0;
        end else if (clk_en && ch2_cycle_end) begin
            max_prev_reg <= ch2_at_max_on && !long_hit;
        end
    end
    // a read-and-clear may release other stops at once, so only the long on-time stop is timed
    AST_OFF_HOLD: assert property (long_hit |-> ##2 !ch2_buck_en [*8])
        else $error("buck two off too briefly");
endmodule // bffs_asserts

bind bffs_top bffs_asserts u_chk (.*);

// >>> dv/bffs_host.sv
// host model: issues status reads and checks the odd parity of each answer
// assumes the read port of bffs_top; drives on the falling edge
`timescale 1ns/100ps
module bffs_host (
    // clock
    input wire logic clk,
    // read port
    output logic rd_strobe,
    output logic rd_clear,
    output logic [3:0] rd_addr,
    input wire logic [23:0] rd_data,
    input wire logic rd_valid,
    // status
    output logic par_bad,
    output logic tmo
);
    initial begin
        rd_strobe = 1'b0;
        rd_clear = 1'b0;
        rd_addr = 4'h0;
        par_bad = 1'b0;
        tmo = 1'b0;
    end
    task automatic rd(input logic c, input logic [3:0] a, output logic [23:0] w);
        int i;
        @(negedge clk);
        rd_strobe = 1'b1;
        rd_clear = c;
        rd_addr = a;
        @(negedge clk);
        rd_strobe = 1'b0;
        rd_clear = 1'b0;
        // the address is meaningless now, so do not leave the old one standing
        rd_addr = ~a;
        w = 'x;
        for (i = 0; i < 4 && rd_valid !== 1'b1; i++) begin
            @(negedge clk);
        end
        if (rd_valid === 1'b1) begin
            w = rd_data;
            par_bad = par_bad | (^w !== 1'b1);
        end else begin
            tmo = 1'b1;
        end
    endtask
endmodule // bffs_host

// >>> dv/testbench.sv
// self-checking bench for bffs_top with a host model on the read port
// assumes the restart period is shortened to 50 cycles
`timescale 1ns/100ps
module testbench;
    import bffs_pkg::*;
    localparam int RC = 50;
    logic clk, rst_b, clk_en, limp_home_mode, rd_strobe, rd_clear, rd_valid, par_bad, tmo;
    logic ch1_tsd_hot, ch1_tw1_hot, ch1_tw2_hot, ch2_tsd_hot, ch2_tw1_hot, ch2_tw2_hot;
    logic ch1_tsd_cool, ch1_tw1_cool, ch1_tw2_cool, ch2_tsd_cool, ch2_tw1_cool, ch2_tw2_cool;
    logic ch1_cycle_end, ch1_short_on, ch1_at_max_on, ch2_cycle_end, ch2_short_on, ch2_at_max_on;
    logic ch1_buck_en, ch2_buck_en;
    logic [3:0] rd_addr;
    logic [23:0] rd_data, got;
    int n_errors = 0;
    int num_checks = 0;
    int n;
    bffs_top #(.RESTART_CYC(RC)) DUT (.*);
    bffs_host host (.*);
    // ****************************************
    // helpers
    // ****************************************
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask
    task automatic rc(input int c, input logic [3:0] a, input logic [23:0] e);
        host.rd(c != 0, a, got);
        if (tmo) begin
            n_errors++;
            complete_run();
        end
        chk("word", {e[23:1], ~^e[23:1]}, got);
    endtask
    task automatic be(input logic [1:0] e);
        chk("buck_en", {22'h00_0000, e}, {22'h00_0000, ch1_buck_en, ch2_buck_en});
    endtask
    // one switching cycle end; ch picks the channels as {ch1, ch2}
    task automatic ev(input logic [1:0] ch, input logic s, input logic m);
        @(negedge clk);
        {ch1_cycle_end, ch2_cycle_end} = ch;
        {ch1_short_on, ch2_short_on, ch1_at_max_on, ch2_at_max_on} = {s, s, m, m};
        @(negedge clk);
        {ch1_cycle_end, ch2_cycle_end} = 2'b00;
    endtask
    task automatic tsd(input int ch, input logic h, input logic c);
        if (ch == 1) begin
            {ch1_tsd_hot, ch1_tsd_cool} = {h, c};
        end else begin
            {ch2_tsd_hot, ch2_tsd_cool} = {h, c};
        end
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset();
        // the enables rise only at the first edge after release
        cyc(2);
        be(2'b11);
        rc(0, BFFS_ADDR_STATUS1, 24'h00_0000);
        rc(1, BFFS_ADDR_STATUS2, 24'h00_0000);
        rc(1, 4'h7, 24'h00_0000);
        $display("test reset done");
    endtask
    task automatic t_warn();
        {ch1_tw1_hot, ch1_tw2_hot, ch2_tw1_hot, ch2_tw2_hot} = 4'hf;
        {ch1_tw1_cool, ch1_tw2_cool, ch2_tw1_cool, ch2_tw2_cool} = 4'h0;
        cyc(6);
        rc(1, BFFS_ADDR_STATUS1, 24'h00_0018);
        rc(1, BFFS_ADDR_STATUS2, 24'h60_0000);
        {ch1_tw1_hot, ch1_tw2_hot, ch2_tw1_hot, ch2_tw2_hot} = 4'h0;
        cyc(6);
        rc(0, BFFS_ADDR_STATUS1, 24'h00_0018);
        rc(0, BFFS_ADDR_STATUS2, 24'h60_0000);
        {ch1_tw1_cool, ch1_tw2_cool, ch2_tw1_cool, ch2_tw2_cool} = 4'hf;
        cyc(6);
        rc(0, BFFS_ADDR_STATUS1, 24'h00_0000);
        rc(0, BFFS_ADDR_STATUS2, 24'h00_0000);
        $display("test warn done");
    endtask
    task automatic t_short();
        repeat (32) ev(2'b11, 1'b1, 1'b0);
        rc(0, BFFS_ADDR_STATUS1, 24'h00_0000);
        clk_en = 1'b0;
        ev(2'b11, 1'b1, 1'b0);
        clk_en = 1'b1;
        rc(0, BFFS_ADDR_STATUS1, 24'h00_0000);
        ev(2'b11, 1'b1, 1'b0);
        cyc(2);
        be(2'b00);
        rc(0, BFFS_ADDR_STATUS1, 24'h00_0006);
        rc(1, BFFS_ADDR_STATUS1, 24'h00_0006);
        cyc(2);
        be(2'b11);
        rc(0, BFFS_ADDR_STATUS1, 24'h00_0000);
        $display("test short done");
    endtask
    task automatic t_long();
        ev(2'b11, 1'b0, 1'b1);
        ev(2'b11, 1'b0, 1'b0);
        ev(2'b11, 1'b0, 1'b1);
        rc(0, BFFS_ADDR_STATUS2, 24'h00_0000);
        ev(2'b11, 1'b0, 1'b1);
        cyc(2);
        be(2'b00);
        n = 0;
        while ((ch1_buck_en & ch2_buck_en) !== 1'b1 && n < 400) begin
            @(negedge clk);
            n++;
        end
        if (n >= 400) begin
            n_errors++;
            complete_run();
        end
        chk("off_len", 24'h00_0001, 24'(n + 5 >= LONG_OFF_CYC && n <= LONG_OFF_CYC + 1));
        rc(0, BFFS_ADDR_STATUS2, 24'h18_0000);
        rc(1, BFFS_ADDR_STATUS2, 24'h18_0000);
        rc(0, BFFS_ADDR_STATUS2, 24'h00_0000);
        $display("test long done");
    endtask
    task automatic overtemp_filter_time(input int ch);
        logic [3:0] a;
        logic [23:0] f;
        a = (ch == 1) ? BFFS_ADDR_STATUS1 : BFFS_ADDR_STATUS2;
        f = (ch == 1) ? 24'h00_0020 : 24'h80_0000;
        tsd(ch, 1'b1, 1'b0);
        cyc(OVT_FILTER_CYC - 40);
        rc(0, a, 24'h00_0000);
        cyc(60);
        rc(0, a, f);
        rc(1, a, f);
        rc(0, a, f);
        be((ch == 1) ? 2'b01 : 2'b10);
        tsd(ch, 1'b0, 1'b1);
        cyc(6);
        rc(1, a, f);
        rc(0, a, 24'h00_0000);
        be(2'b11);
        $display("test overtemp done");
    endtask
    task automatic t_limp();
        limp_home_mode = 1'b1;
        tsd(1, 1'b1, 1'b0);
        cyc(OVT_FILTER_CYC + 10);
        repeat (33) ev(2'b10, 1'b1, 1'b0);
        ev(2'b10, 1'b0, 1'b1);
        ev(2'b10, 1'b0, 1'b1);
        cyc(RC + 5);
        rc(0, BFFS_ADDR_STATUS1, 24'h00_0020);
        rc(0, BFFS_ADDR_STATUS2, 24'h00_0000);
        tsd(1, 1'b0, 1'b1);
        cyc(RC + 5);
        rc(0, BFFS_ADDR_STATUS1, 24'h00_0000);
        cyc(LONG_OFF_CYC);
        be(2'b11);
        limp_home_mode = 1'b0;
        $display("test limp done");
    endtask
    // ****************************************
    // run
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        {rst_b, clk_en, limp_home_mode} = 3'h2;
        {ch1_tsd_hot, ch1_tw1_hot, ch1_tw2_hot, ch2_tsd_hot, ch2_tw1_hot, ch2_tw2_hot} = 6'h00;
        {ch1_tsd_cool, ch1_tw1_cool, ch1_tw2_cool, ch2_tsd_cool, ch2_tw1_cool, ch2_tw2_cool} = 6'h3f;
        {ch1_cycle_end, ch1_short_on, ch1_at_max_on} = 3'h0;
        {ch2_cycle_end, ch2_short_on, ch2_at_max_on} = 3'h0;
        repeat (20) @(posedge clk);
        @(negedge clk);
        rst_b = 1'b1;
        t_reset();
        t_warn();
        t_short();
        t_long();
        overtemp_filter_time(1);
        overtemp_filter_time(2);
        t_limp();
        chk("parity", 24'h00_0000, {23'h00_0000, par_bad});
        complete_run();
    end
    // a hang anywhere ends the run as a mismatch
    initial begin
        repeat (100000) @(posedge clk);
        n_errors++;
        complete_run();
    end
endmodule // testbench

// >>> verilog/bffs_channel.sv
// one buck channel: short and long on-time detection, long on-time off timer
// assumes event strobes are one-cycle pulses on the device clock
`timescale 1ns/100ps
module bffs_channel
    import bffs_pkg::*;
#(
    parameter int OFF_CYC = LONG_OFF_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clk_en,
    // switching cycle events
    input wire logic cycle_end,
    input wire logic short_on,
    input wire logic at_max_on,
    // clears
    input wire logic clr_short,
    input wire logic clr_long,
    // flags
    output logic short_flag,
    output logic long_flag,
    output logic long_off
);
    logic [5:0] short_cnt_reg;
    logic prev_max_reg;
    logic [15:0] off_cnt_reg;
    logic long_evt;

    assign long_evt = cycle_end && at_max_on && prev_max_reg;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            short_cnt_reg <= 6'h00;
            short_flag <= 1'b0;
        end else if (clk_en) begin
            if (cycle_end && short_on && short_cnt_reg <= SHORT_CYCLE_LIMIT) begin
                short_cnt_reg <= short_cnt_reg + 6'h01;
            end
            if (cycle_end && short_on && short_cnt_reg == SHORT_CYCLE_LIMIT) begin
                short_flag <= 1'b1;
                short_cnt_reg <= 6'h00;
            end else if (clr_short) begin
                short_flag <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prev_max_reg <= 1'b0;
            long_flag <= 1'b0;
            off_cnt_reg <= 16'h0000;
            long_off <= 1'b0;
        end else if (clk_en) begin
            if (cycle_end) begin
                prev_max_reg <= at_max_on && !long_evt;
            end
            // set wins over a simultaneous clear
            if (long_evt) begin
                long_flag <= 1'b1;
            end else if (clr_long) begin
                long_flag <= 1'b0;
            end
            if (long_evt) begin
                off_cnt_reg <= 16'(OFF_CYC - 1);
                long_off <= 1'b1;
            end else if (off_cnt_reg != 16'h0000) begin
                off_cnt_reg <= off_cnt_reg - 16'h0001;
            end else begin
                long_off <= 1'b0;
            end
        end
    end
endmodule // bffs_channel

// >>> verilog/bffs_pkg.sv
// package for buck fault status flag logic: offsets, field positions, timing counts
// assumes a 20 MHz device clock
package bffs_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [3:0] BFFS_ADDR_STATUS1 = 4'h5;
    localparam logic [3:0] BFFS_ADDR_STATUS2 = 4'h6;
    localparam int BFFS_WORD_W = 24;
    localparam logic [23:0] BFFS_RESET_WORD = 24'h00_0000;
    // thermal_ontime_diag_status fields
    localparam int S2_CH2_OVT = 23;
    localparam int S2_CH2_WARN2 = 22;
    localparam int S2_CH2_WARN1 = 21;
    localparam int S2_CH1_LONG = 20;
    localparam int S2_CH2_LONG = 19;
    // buck_output_diag_status fields
    localparam int S1_CH1_OVT = 5;
    localparam int S1_CH1_WARN2 = 4;
    localparam int S1_CH1_WARN1 = 3;
    localparam int S1_CH1_SHORT = 2;
    localparam int S1_CH2_SHORT = 1;
    localparam int PARITY_BIT = 0;
    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_HZ = 20_000_000;
    localparam int OVT_FILTER_US = 32;
    localparam int OVT_FILTER_CYC = (OVT_FILTER_US * (CLK_HZ / 1_000_000));
    localparam int AUTO_RESTART_MS = 100;
    localparam int AUTO_RESTART_CYC = AUTO_RESTART_MS * (CLK_HZ / 1000);
    localparam int LONG_OFF_US = 10;
    localparam int LONG_OFF_CYC = LONG_OFF_US * (CLK_HZ / 1_000_000);
    localparam logic [5:0] SHORT_CYCLE_LIMIT = 6'h20;
endpackage

// >>> verilog/bffs_top.sv
// fault status flag logic for two buck channels with read-and-clear status words
// assumes temperature comparator levels arrive from the analog side (async pins)
// How it works
// - in active mode channel-one over-temperature is flagged only after the indication outlasts the filter.
// - in active mode that flag holds buck one off until a read-and-clear below hysteresis.
// - in limp home the flag is re-checked each restart period and cleared only if below hysteresis.
// - the level-two warnings are live, unlatched bits with hysteresis.
// - the level-one warnings are live, unlatched bits with hysteresis.
// - more than 32 short on-time cycles, not consecutive, set the short on-time flag.
// - a set short on-time flag keeps its buck off until a read-and-clear.
// - in limp home the channel-one short on-time flag is cleared each restart period.
// - channel-two over-temperature holds buck two off until a valid read-and-clear.
// - two consecutive cycles at maximum on-time set the long on-time flag.
// - each long on-time event idles the buck for an off interval; the flag stays latched.
// - in limp home the channel-one long on-time flag is cleared each restart period.
// - the second status word answers at address six with mixed field access.
// - bit 0 of every status word makes the word's parity odd.
`timescale 1ns/100ps
module bffs_top
    import bffs_pkg::*;
#(
    parameter int RESTART_CYC = AUTO_RESTART_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clk_en,
    // mode
    input wire logic limp_home_mode,
    // temperature comparators, per channel: shutdown, hysteresis-release, warnings
    input wire logic ch1_tsd_hot,
    input wire logic ch1_tsd_cool,
    input wire logic ch1_tw1_hot,
    input wire logic ch1_tw1_cool,
    input wire logic ch1_tw2_hot,
    input wire logic ch1_tw2_cool,
    input wire logic ch2_tsd_hot,
    input wire logic ch2_tsd_cool,
    input wire logic ch2_tw1_hot,
    input wire logic ch2_tw1_cool,
    input wire logic ch2_tw2_hot,
    input wire logic ch2_tw2_cool,
    // switching cycle events from the buck controllers
    input wire logic ch1_cycle_end,
    input wire logic ch1_short_on,
    input wire logic ch1_at_max_on,
    input wire logic ch2_cycle_end,
    input wire logic ch2_short_on,
    input wire logic ch2_at_max_on,
    // status access from the serial front end
    input wire logic rd_strobe,
    input wire logic rd_clear,
    input wire logic [3:0] rd_addr,
    output logic [23:0] rd_data,
    output logic rd_valid,
    // buck enables
    output logic ch1_buck_en,
    output logic ch2_buck_en
);
    // ****************************************
    // synchronisers: change counts once stages two and three agree
    // ****************************************
    localparam int NSYNC = 12;
    logic [NSYNC-1:0] raw_in, s1_reg, s2_reg, s3_reg, lvl_reg;
    assign raw_in = {ch1_tsd_hot, ch1_tsd_cool, ch1_tw1_hot, ch1_tw1_cool, ch1_tw2_hot,
        ch1_tw2_cool, ch2_tsd_hot, ch2_tsd_cool, ch2_tw1_hot, ch2_tw1_cool, ch2_tw2_hot,
        ch2_tw2_cool};

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            lvl_reg <= '0;
        end else if (clk_en) begin
            s1_reg <= raw_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            lvl_reg <= (s2_reg & s3_reg) | (lvl_reg & (s2_reg | s3_reg));
        end
    end

    logic t1_hot, t1_cool, t1w1h, t1w1c, t1w2h, t1w2c;
    logic t2_hot, t2_cool, t2w1h, t2w1c, t2w2h, t2w2c;
    assign {t1_hot, t1_cool, t1w1h, t1w1c, t1w2h, t1w2c,
        t2_hot, t2_cool, t2w1h, t2w1c, t2w2h, t2w2c} = lvl_reg;

    function automatic logic odd_par(input logic [23:1] w);
        return ~^w;
    endfunction

    // ****************************************
    // live warnings with hysteresis
    // ****************************************
    logic ch1_warn_level1, ch1_warn_level2, ch2_warn_level1, ch2_warn_level2;

    function automatic logic hyst(input logic cur, input logic hot, input logic cool);
        return hot ? 1'b1 : (cool ? 1'b0 : cur);
    endfunction

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ch1_warn_level1 <= 1'b0;
            ch1_warn_level2 <= 1'b0;
            ch2_warn_level1 <= 1'b0;
            ch2_warn_level2 <= 1'b0;
        end else if (clk_en) begin
            ch1_warn_level2 <= hyst(ch1_warn_level2, t1w2h, t1w2c);
            ch2_warn_level2 <= hyst(ch2_warn_level2, t2w2h, t2w2c);
            ch1_warn_level1 <= hyst(ch1_warn_level1, t1w1h, t1w1c);
            ch2_warn_level1 <= hyst(ch2_warn_level1, t2w1h, t2w1c);
        end
    end

    // ****************************************
    // over-temperature filters and auto-restart timer
    // ****************************************
    logic [9:0] f1_cnt_reg, f2_cnt_reg;
    logic ch1_overtemp_flag_evt, ch2_overtemp_flag_evt;
    logic [23:0] restart_cnt_reg;
    logic restart_tick;

    // "more than" the filter time: the flag fires one cycle past the count
    assign ch1_overtemp_flag_evt = t1_hot && (f1_cnt_reg == 10'(OVT_FILTER_CYC));
    assign ch2_overtemp_flag_evt = t2_hot && (f2_cnt_reg == 10'(OVT_FILTER_CYC));
    assign restart_tick = limp_home_mode && (restart_cnt_reg == 24'h00_0000);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            f1_cnt_reg <= 10'h000;
            f2_cnt_reg <= 10'h000;
        end else if (clk_en) begin
            f1_cnt_reg <= !t1_hot ? 10'h000 : (ch1_overtemp_flag_evt ? f1_cnt_reg : f1_cnt_reg + 10'h001);
            f2_cnt_reg <= !t2_hot ? 10'h000 : (ch2_overtemp_flag_evt ? f2_cnt_reg : f2_cnt_reg + 10'h001);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            restart_cnt_reg <= 24'h00_0000;
        end else if (clk_en) begin
            if (!limp_home_mode || restart_tick) begin
                restart_cnt_reg <= 24'(RESTART_CYC - 1);
            end else begin
                restart_cnt_reg <= restart_cnt_reg - 24'h00_0001;
            end
        end
    end

    // ****************************************
    // read-and-clear decode
    // ****************************************
    logic rc1, rc2;
    assign rc1 = rd_strobe && rd_clear && rd_addr == BFFS_ADDR_STATUS1;
    assign rc2 = rd_strobe && rd_clear && rd_addr == BFFS_ADDR_STATUS2;

    logic ch1_short_ontime_flag, ch2_short_ontime_flag;
    logic ch1_long_ontime_flag, ch2_long_ontime_flag;
    logic ch1_long_off, ch2_long_off;

    bffs_channel u_ch1 (
        .clk(clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .cycle_end(ch1_cycle_end),
        .short_on(ch1_short_on),
        .at_max_on(ch1_at_max_on),
        .clr_short(rc1 || restart_tick),
        .clr_long(rc2 || restart_tick),
        .short_flag(ch1_short_ontime_flag),
        .long_flag(ch1_long_ontime_flag),
        .long_off(ch1_long_off)
    );

    bffs_channel u_ch2 (
        .clk(clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .cycle_end(ch2_cycle_end),
        .short_on(ch2_short_on),
        .at_max_on(ch2_at_max_on),
        .clr_short(rc1),
        .clr_long(rc2),
        .short_flag(ch2_short_ontime_flag),
        .long_flag(ch2_long_ontime_flag),
        .long_off(ch2_long_off)
    );

    // ****************************************
    // over-temperature flags
    // ****************************************
    logic ch1_overtemp_flag, ch2_overtemp_flag;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ch1_overtemp_flag <= 1'b0;
            ch2_overtemp_flag <= 1'b0;
        end else if (clk_en) begin
            if (ch1_overtemp_flag_evt) begin
                ch1_overtemp_flag <= 1'b1;
            end else if (restart_tick) begin
                ch1_overtemp_flag <= !t1_cool;
            end else if (rc1 && t1_cool) begin
                ch1_overtemp_flag <= 1'b0;
            end
            if (ch2_overtemp_flag_evt) begin
                ch2_overtemp_flag <= 1'b1;
            end else if (rc2 && t2_cool) begin
                ch2_overtemp_flag <= 1'b0;
            end
        end
    end

    // ****************************************
    // buck gating
    // ****************************************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ch1_buck_en <= 1'b0;
            ch2_buck_en <= 1'b0;
        end else if (clk_en) begin
            ch1_buck_en <= !ch1_overtemp_flag && !ch1_short_ontime_flag
                && !ch1_long_off;
            ch2_buck_en <= !ch2_overtemp_flag && !ch2_short_ontime_flag
                && !ch2_long_off;
        end
    end

    // ****************************************
    // status words: sampled before the clear lands
    // ****************************************
    logic [23:1] w1, w2;
    always_comb begin
        w1 = '0;
        w1[S1_CH1_OVT] = ch1_overtemp_flag;
        w1[S1_CH1_WARN2] = ch1_warn_level2;
        w1[S1_CH1_WARN1] = ch1_warn_level1;
        w1[S1_CH1_SHORT] = ch1_short_ontime_flag;
        w1[S1_CH2_SHORT] = ch2_short_ontime_flag;
        w2 = '0;
        w2[S2_CH2_OVT] = ch2_overtemp_flag;
        w2[S2_CH2_WARN2] = ch2_warn_level2;
        w2[S2_CH2_WARN1] = ch2_warn_level1;
        w2[S2_CH1_LONG] = ch1_long_ontime_flag;
        w2[S2_CH2_LONG] = ch2_long_ontime_flag;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_data <= BFFS_RESET_WORD;
            rd_valid <= 1'b0;
        end else if (clk_en) begin
            rd_valid <= rd_strobe;
            if (rd_strobe) begin
                if (rd_addr == BFFS_ADDR_STATUS2) begin
                    rd_data <= {w2, odd_par(w2)};
                end else if (rd_addr == BFFS_ADDR_STATUS1) begin
                    rd_data <= {w1, odd_par(w1)};
                end else begin
                    rd_data <= {23'h00_0000, 1'b1};
                end
            end
        end
    end
endmodule // bffs_top
